//--- idbc_ctrl.sv
// idbc_ctrl.sv: bus-side control of a four-way interleaved 16 MB dram board.
// assumes all bus and internal-bus inputs are asynchronous to clk and that the bench resolves shared wires from the enables.
//
// Functional notes
// - claim memory only when address 31:24 equals the board's 16 MB region
// - address 23:05 picks the cache block inside the board
// - memory transactions are whole 32-byte blocks; masters issue nothing else
// - the four lines of a block go to banks zero, one, two, three in order
// - address bit 23 picks the high half when one, low half when zero
// - each word is 64 data plus 8 check bits, both carried
// - base address is a software-written register used by the decoder
// - address latch follows the low 24 address bits while strobe is asserted
// - first bus clock edge after strobe release loads registered address when enabled
// - latched address feeds banks zero/one, registered feeds banks two/three and io
// - eight-bit compare against base raises board select for memory types
// - eight-bit compare of space, slot id and address 27:24 raises io select
// - separate high and low row, column and output strobes for four banks
// - write signals asserted on writes, deasserted on reads
// - every bank-half strobe is driven as three identical copies
// - banks zero and two use internal pair a, banks one and three pair b
// - two write registers alternate lines, each driving its pair only when enabled
// - read register drives bus data and check bits only under its enable
// - read multiplexer merges both pairs into the read register under two selects
// - io read data sits on bits 63:56 of internal data bus b
// - board timing is rebuilt from the system bus clock
// - controller drives the handshake completing each claimed transaction
// - address select high sends bits 22:14 as row, low sends 13:05 as column
// - answer byte io in space 0001 when address 27:24 equals slot id
`timescale 1ns/1ps
`include "idbc_consts.svh"

module idbc_ctrl (
	input wire logic clk,
	input wire logic resetn,
	input wire logic bus_clock,
	output logic rebuilt_bus_clock,
	input wire logic bus_address_strobe_n,
	input wire logic [2:0] bus_cmd,
	input wire logic [3:0] bus_space_code,
	input wire logic [3:0] board_id_bus,
	input wire logic [31:0] bus_addr,
	input wire logic [63:0] bus_data_in,
	input wire logic [7:0] bus_check_bits_in,
	output logic [63:0] bus_data_out,
	output logic [7:0] bus_check_bits_out,
	output logic bus_data_oe,
	output logic bus_ack_n_out,
	output logic bus_ack_oe,
	input wire logic [63:0] int_data_a_in,
	input wire logic [7:0] int_check_a_in,
	output logic [63:0] int_data_a_out,
	output logic [7:0] int_check_a_out,
	output logic int_a_oe,
	input wire logic [63:0] int_data_b_in,
	input wire logic [7:0] int_check_b_in,
	output logic [63:0] int_data_b_out,
	output logic [7:0] int_check_b_out,
	output logic int_b_oe,
	output logic wr_reg_a_oe_n,
	output logic wr_reg_b_oe_n,
	output logic rd_reg_oe_n,
	output logic rd_mux_sel0_n,
	output logic rd_mux_sel1_n,
	output logic addr_reg_enable_n,
	output logic [23:0] latched_addr,
	output logic [23:0] registered_addr,
	output logic [3:0] row_col_sel_bank_n,
	output logic [3:0][8:0] dram_addr,
	output idbc_pkg::idbc_strobe_t [3:0][1:0] dram_ctl,
	output logic board_sel,
	output logic io_sel,
	output logic [7:0] base_addr
);
	import idbc_pkg::*;

	localparam int BIN_W = $bits(idbc_bus_in_t);

	idbc_bus_in_t bus_raw;
	idbc_bus_in_t bus_s1_r;
	idbc_bus_in_t bus_s2_r;
	idbc_word_t ia_s1_r;
	idbc_word_t ia_s2_r;
	idbc_word_t ib_s1_r;
	idbc_word_t ib_s2_r;
	logic clk_s1_r;
	logic clk_s2_r;
	logic clk_prev_r;
	logic bclk_en;
	logic strobe_act;

	idbc_state_t state_r, state_nxt;
	logic [1:0] bank_r, bank_nxt;
	logic wr_r, wr_nxt;
	logic io_r, io_nxt;
	logic strb_seen_r, strb_seen_nxt;
	logic [23:0] latched_r, latched_nxt;
	logic [7:0] ltop_r, ltop_nxt;
	logic [2:0] lcmd_r, lcmd_nxt;
	logic [3:0] lspace_r, lspace_nxt;
	logic [3:0] lid_r, lid_nxt;
	logic [23:0] reg_r, reg_nxt;
	logic [7:0] base_r, base_nxt;
	logic board_sel_r, board_sel_nxt;
	logic io_sel_r, io_sel_nxt;
	idbc_word_t wr_a_r, wr_a_nxt;
	idbc_word_t wr_b_r, wr_b_nxt;
	idbc_word_t rd_r, rd_nxt;
	logic mem_hit;
	logic io_hit;
	logic mem_type;
	logic io_type;
	logic load_ra;
	logic ras_on;
	logic cas_on;
	logic col_phase;

	assign bus_raw = {bus_address_strobe_n, bus_cmd, bus_space_code, board_id_bus, bus_addr,
		bus_data_in, bus_check_bits_in};

	// two-stage synchronisers; only the second stage is read by logic
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bus_s1_r <= {1'b1, {(BIN_W - 1){1'b0}}};
			bus_s2_r <= {1'b1, {(BIN_W - 1){1'b0}}};
			ia_s1_r <= '0;
			ia_s2_r <= '0;
			ib_s1_r <= '0;
			ib_s2_r <= '0;
			clk_s1_r <= 1'b0;
			clk_s2_r <= 1'b0;
			clk_prev_r <= 1'b0;
		end else begin
			bus_s1_r <= bus_raw;
			bus_s2_r <= bus_s1_r;
			ia_s1_r <= {int_data_a_in, int_check_a_in};
			ia_s2_r <= ia_s1_r;
			ib_s1_r <= {int_data_b_in, int_check_b_in};
			ib_s2_r <= ib_s1_r;
			clk_s1_r <= bus_clock;
			clk_s2_r <= clk_s1_r;
			clk_prev_r <= clk_s2_r;
		end
	end

	// board steps once per rising bus clock edge, so all sequencing stays in step with the bus
	assign bclk_en = clk_s2_r & ~clk_prev_r;
	assign rebuilt_bus_clock = clk_s2_r;
	assign strobe_act = ~bus_s2_r.strobe_n;

	assign mem_type = (lcmd_r == `IDBC_CMD_MEM_RD) || (lcmd_r == `IDBC_CMD_MEM_WR);
	assign io_type = (lcmd_r == `IDBC_CMD_IO_RD) || (lcmd_r == `IDBC_CMD_IO_WR);
	// region always starts on a 16 MB boundary, so only the top byte is compared
	assign mem_hit = mem_type && (ltop_r == base_r);
	assign io_hit = io_type && ({lspace_r, ltop_r[3:0]} == {`IDBC_IO_SPACE, lid_r});
	assign addr_reg_enable_n = ~((state_r == ST_IDLE) && strb_seen_r && !strobe_act);
	assign load_ra = bclk_en && !addr_reg_enable_n;

	always_comb begin
		state_nxt = state_r;
		bank_nxt = bank_r;
		wr_nxt = wr_r;
		io_nxt = io_r;
		strb_seen_nxt = strb_seen_r;
		latched_nxt = latched_r;
		ltop_nxt = ltop_r;
		lcmd_nxt = lcmd_r;
		lspace_nxt = lspace_r;
		lid_nxt = lid_r;
		reg_nxt = reg_r;
		base_nxt = base_r;
		board_sel_nxt = board_sel_r;
		io_sel_nxt = io_sel_r;
		wr_a_nxt = wr_a_r;
		wr_b_nxt = wr_b_r;
		rd_nxt = rd_r;
		// transparent while the strobe is asserted; a strobe during a busy block moves banks zero/one addressing
		if (strobe_act) begin
			latched_nxt = bus_s2_r.addr[23:0];
			ltop_nxt = bus_s2_r.addr[`IDBC_REGION_MSB:`IDBC_REGION_LSB];
			lcmd_nxt = bus_s2_r.cmd;
			lspace_nxt = bus_s2_r.space;
			lid_nxt = bus_s2_r.id;
			if (state_r == ST_IDLE) begin
				strb_seen_nxt = 1'b1;
			end
		end
		if (load_ra) begin
			reg_nxt = latched_r;
			strb_seen_nxt = 1'b0;
			bank_nxt = 2'h0;
			board_sel_nxt = mem_hit;
			io_sel_nxt = io_hit;
			io_nxt = io_hit;
			wr_nxt = (lcmd_r == `IDBC_CMD_MEM_WR) || (lcmd_r == `IDBC_CMD_IO_WR);
			if (mem_hit) begin
				state_nxt = (lcmd_r == `IDBC_CMD_MEM_WR) ? ST_WIN : ST_ROW;
			end else if (io_hit) begin
				state_nxt = ST_IO;
				if (latched_r[`IDBC_IODEV_MSB:`IDBC_IODEV_LSB] == `IDBC_IO_LOCREG) begin
					wr_b_nxt = {base_r, 56'h0000_0000_0000_00, 8'h00};
				end else begin
					wr_b_nxt = '0;
				end
			end else begin
				state_nxt = ST_IDLE;
			end
		end else if (bclk_en) begin
			case (state_r)
				ST_WIN: begin
					// lines alternate between the two write registers
					if (bank_r[0]) begin
						wr_b_nxt = bus_s2_r.word;
					end else begin
						wr_a_nxt = bus_s2_r.word;
					end
					state_nxt = ST_ROW;
				end
				ST_ROW: begin
					state_nxt = ST_COL;
				end
				ST_COL: begin
					state_nxt = ST_XFER;
				end
				ST_XFER: begin
					if (!wr_r) begin
						rd_nxt = bank_r[0] ? ib_s2_r : ia_s2_r;
						state_nxt = ST_RDOUT;
					end else if (bank_r == `IDBC_LAST_BANK) begin
						state_nxt = ST_IDLE;
						board_sel_nxt = 1'b0;
					end else begin
						bank_nxt = bank_r + 2'h1;
						state_nxt = ST_WIN;
					end
				end
				ST_RDOUT: begin
					if (io_r || (bank_r == `IDBC_LAST_BANK)) begin
						state_nxt = ST_IDLE;
						board_sel_nxt = 1'b0;
						io_sel_nxt = 1'b0;
					end else begin
						bank_nxt = bank_r + 2'h1;
						state_nxt = ST_ROW;
					end
				end
				ST_IO: begin
					if (wr_r) begin
						// io devices are byte wide, only the top byte lane carries data
						if (reg_r[`IDBC_IODEV_MSB:`IDBC_IODEV_LSB] == `IDBC_IO_LOCREG) begin
							base_nxt = bus_s2_r.word.data[`IDBC_IODATA_MSB:`IDBC_IODATA_LSB];
						end
						state_nxt = ST_IDLE;
						io_sel_nxt = 1'b0;
					end else begin
						rd_nxt = ib_s2_r;
						state_nxt = ST_RDOUT;
					end
				end
				default: begin
					state_nxt = ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_r <= ST_IDLE;
			bank_r <= 2'h0;
			wr_r <= 1'b0;
			io_r <= 1'b0;
			strb_seen_r <= 1'b0;
			latched_r <= 24'h00_0000;
			ltop_r <= 8'h00;
			lcmd_r <= `IDBC_CMD_IDLE;
			lspace_r <= 4'h0;
			lid_r <= 4'h0;
			reg_r <= 24'h00_0000;
			base_r <= `IDBC_BASE_RST;
			board_sel_r <= 1'b0;
			io_sel_r <= 1'b0;
			wr_a_r <= '0;
			wr_b_r <= '0;
			rd_r <= '0;
		end else begin
			state_r <= state_nxt;
			bank_r <= bank_nxt;
			wr_r <= wr_nxt;
			io_r <= io_nxt;
			strb_seen_r <= strb_seen_nxt;
			latched_r <= latched_nxt;
			ltop_r <= ltop_nxt;
			lcmd_r <= lcmd_nxt;
			lspace_r <= lspace_nxt;
			lid_r <= lid_nxt;
			reg_r <= reg_nxt;
			base_r <= base_nxt;
			board_sel_r <= board_sel_nxt;
			io_sel_r <= io_sel_nxt;
			wr_a_r <= wr_a_nxt;
			wr_b_r <= wr_b_nxt;
			rd_r <= rd_nxt;
		end
	end

	assign ras_on = (state_r == ST_ROW) || (state_r == ST_COL) || (state_r == ST_XFER);
	assign col_phase = (state_r == ST_COL) || (state_r == ST_XFER);
	assign cas_on = col_phase;

	genvar gb, gh;
	generate
		for (gb = 0; gb < 4; gb++) begin : g_bank
			logic bank_act;
			logic [23:0] src;
			assign bank_act = ras_on && (bank_r == 2'(gb));
			// banks two and three follow the registered copy, which holds after the latch reopens
			assign src = (gb < 2) ? latched_r : reg_r;
			assign row_col_sel_bank_n[gb] = ~(bank_act && col_phase);
			assign dram_addr[gb] = row_col_sel_bank_n[gb] ? src[`IDBC_ROW_MSB:`IDBC_ROW_LSB]
				: src[`IDBC_COL_MSB:`IDBC_COL_LSB];
			for (gh = 0; gh < 2; gh++) begin : g_half
				logic on;
				assign on = bank_act && (reg_r[`IDBC_HALF_BIT] == 1'(gh));
				assign dram_ctl[gb][gh].ras_n = {3{~on}};
				assign dram_ctl[gb][gh].cas_n = {3{~(on && cas_on)}};
				assign dram_ctl[gb][gh].oe_n = {3{~(on && cas_on && !wr_r)}};
				assign dram_ctl[gb][gh].dram_write_dir = {3{on && cas_on && wr_r}};
			end
		end
	endgenerate

	assign wr_reg_a_oe_n = ~(wr_r && col_phase && !bank_r[0]);
	assign wr_reg_b_oe_n = ~((wr_r && col_phase && bank_r[0]) || (io_r && !wr_r && (state_r == ST_IO)));
	assign int_a_oe = ~wr_reg_a_oe_n;
	assign int_b_oe = ~wr_reg_b_oe_n;
	assign int_data_a_out = wr_a_r.data;
	assign int_check_a_out = wr_a_r.check;
	assign int_data_b_out = wr_b_r.data;
	assign int_check_b_out = wr_b_r.check;

	assign rd_mux_sel0_n = ~(!wr_r && (state_r == ST_XFER) && !bank_r[0]);
	assign rd_mux_sel1_n = ~(!wr_r && (((state_r == ST_XFER) && bank_r[0]) || (io_r && (state_r == ST_IO))));
	assign rd_reg_oe_n = ~(state_r == ST_RDOUT);
	assign bus_data_oe = (state_r == ST_RDOUT);
	assign bus_data_out = rd_r.data;
	assign bus_check_bits_out = rd_r.check;

	// handshake only while a claimed transaction moves a word
	assign bus_ack_oe = (state_r == ST_WIN) || (state_r == ST_RDOUT) || ((state_r == ST_IO) && wr_r);
	assign bus_ack_n_out = ~bus_ack_oe;

	assign latched_addr = latched_r;
	assign registered_addr = reg_r;
	assign board_sel = board_sel_r;
	assign io_sel = io_sel_r;
	assign base_addr = base_r;

endmodule : idbc_ctrl

//--- idbc_consts.svh
// idbc_consts.svh: offsets, field positions, codes and reset values for the interleaved dram board controller.
// assumes it is included by its bare name wherever these values are needed.
`ifndef IDBC_CONSTS_SVH
`define IDBC_CONSTS_SVH

// transaction type codes presented on bus_cmd
`define IDBC_CMD_IDLE 3'h0
`define IDBC_CMD_MEM_RD 3'h1
`define IDBC_CMD_MEM_WR 3'h2
`define IDBC_CMD_IO_RD 3'h3
`define IDBC_CMD_IO_WR 3'h4

// io space served by the board and the io device select value of the base-location register
`define IDBC_IO_SPACE 4'h1
`define IDBC_IO_LOCREG 2'h2

// address fields
`define IDBC_REGION_MSB 31
`define IDBC_REGION_LSB 24
`define IDBC_SLOT_MSB 27
`define IDBC_SLOT_LSB 24
`define IDBC_HALF_BIT 23
`define IDBC_ROW_MSB 22
`define IDBC_ROW_LSB 14
`define IDBC_COL_MSB 13
`define IDBC_COL_LSB 5
`define IDBC_IODEV_MSB 17
`define IDBC_IODEV_LSB 16
`define IDBC_IODATA_MSB 63
`define IDBC_IODATA_LSB 56

// reset values and sequence limits
`define IDBC_BASE_RST 8'h00
`define IDBC_LAST_BANK 2'h3

`endif

//--- idbc_pkg.sv
// idbc_pkg.sv: types shared by the interleaved dram board controller.
// assumes nothing beyond a SystemVerilog compiler.
package idbc_pkg;

	// one stored word: 64 data bits and 8 check bits
	typedef struct packed {
		logic [63:0] data;
		logic [7:0] check;
	} idbc_word_t;

	// per bank-half strobes, each as three identical copies a, b, c
	typedef struct packed {
		logic [2:0] ras_n;
		logic [2:0] cas_n;
		logic [2:0] oe_n;
		logic [2:0] dram_write_dir;
	} idbc_strobe_t;

	// bus inputs that travel together through the synchroniser; strobe_n is the msb
	typedef struct packed {
		logic strobe_n;
		logic [2:0] cmd;
		logic [3:0] space;
		logic [3:0] id;
		logic [31:0] addr;
		idbc_word_t word;
	} idbc_bus_in_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WIN,
		ST_ROW,
		ST_COL,
		ST_XFER,
		ST_RDOUT,
		ST_IO
	} idbc_state_t;

endpackage : idbc_pkg

//--- idbc_ctrl_asserts.sv
// idbc_ctrl_asserts.sv: port-level checks on the interleaved dram board controller.
// assumes it is bound into idbc_ctrl and sees nothing but that module's ports.
`timescale 1ns/1ps
module idbc_ctrl_asserts (
	input wire logic clk,
	input wire logic resetn,
	input wire logic bus_clock,
	input wire logic rebuilt_bus_clock,
	input wire logic bus_address_strobe_n,
	input wire logic [23:0] latched_addr,
	input wire logic bus_ack_n_out,
	input wire logic bus_ack_oe,
	input wire logic bus_data_oe,
	input wire logic rd_reg_oe_n,
	input wire logic rd_mux_sel0_n,
	input wire logic rd_mux_sel1_n,
	input wire logic wr_reg_a_oe_n,
	input wire logic addr_reg_enable_n,
	input wire logic [23:0] registered_addr,
	input wire idbc_pkg::idbc_strobe_t [3:0][1:0] dram_ctl,
	input wire logic board_sel,
	input wire logic io_sel
);
	import idbc_pkg::*;
	logic split, wrong_half, ras_any, wrt_a;
	function automatic logic mixed(input logic [2:0] v);
		return (&v) != (|v);
	endfunction : mixed
	always_comb begin
		idbc_strobe_t s;
		s = '0;
		split = 1'b0;
		wrong_half = 1'b0;
		ras_any = 1'b0;
		wrt_a = 1'b0;
		for (int b = 0; b < 4; b++) begin
			for (int h = 0; h < 2; h++) begin
				s = dram_ctl[b][h];
				split |= mixed(s.ras_n) | mixed(s.cas_n) | mixed(s.oe_n) | mixed(s.dram_write_dir);
				if (((h == 1) != registered_addr[23]) && !(&s.ras_n))
					wrong_half = 1'b1;
				ras_any |= !(&s.ras_n);
				if (b % 2 == 0)
					wrt_a |= |s.dram_write_dir;
			end
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_ack_polarity: assert property ((bus_ack_n_out != bus_ack_oe) && (!bus_data_oe || bus_ack_oe))
		else $error("ack line wrong or read data without ack");
	a_rbc_follow: assert property ($past(resetn, 2) |-> rebuilt_bus_clock == $past(bus_clock, 2))
		else $error("rebuilt bus clock does not follow the bus clock");
	a_latch_gate: assert property ($changed(latched_addr) |-> !$past(bus_address_strobe_n, 3))
		else $error("address latch moved without the strobe");
	a_copies_same: assert property (!split)
		else $error("strobe copies disagree");
	a_half_pick: assert property (!wrong_half)
		else $error("row strobe on the wrong half");
	a_write_dir: assert property (wrt_a |-> !wr_reg_a_oe_n && rd_reg_oe_n)
		else $error("write strobe without write register drive");
	a_read_gate: assert property (bus_data_oe |-> !rd_reg_oe_n)
		else $error("bus driven without read register enable");
	a_mux_excl: assert property (rd_mux_sel0_n || rd_mux_sel1_n)
		else $error("both read mux selects active");
	a_claim_only: assert property (bus_ack_oe |-> board_sel || io_sel)
		else $error("ack on an unclaimed transaction");
	a_dram_idle: assert property (!board_sel ##1 !board_sel |-> !ras_any)
		else $error("row strobe while board not selected");
	a_areg_load: assert property ($changed(registered_addr) |-> $past(addr_reg_enable_n) == 1'b0)
		else $error("address register loaded while not enabled");
	c_mem_write: cover property (wrt_a);
	c_mem_read: cover property (bus_data_oe && board_sel);
	c_io_cycle: cover property (io_sel && bus_ack_oe);
endmodule : idbc_ctrl_asserts

bind idbc_ctrl idbc_ctrl_asserts idbc_ctrl_asserts_i (.clk, .resetn, .bus_clock, .rebuilt_bus_clock,
	.bus_address_strobe_n, .latched_addr, .bus_ack_n_out, .bus_ack_oe, .bus_data_oe,
	.rd_reg_oe_n, .rd_mux_sel0_n, .rd_mux_sel1_n, .wr_reg_a_oe_n, .addr_reg_enable_n, .registered_addr,
	.dram_ctl, .board_sel, .io_sel);

//--- idbc_bus_master.sv
// idbc_bus_master.sv: behavioural backplane master issuing one transaction at a time.
// assumes the bench calls xact sequentially; the bus clock runs free like a backplane clock.
`timescale 1ns/1ps
`include "idbc_consts.svh"
module idbc_bus_master
	import idbc_pkg::*;
(
	input wire logic clk,
	input wire logic bus_ack_oe,
	output logic bus_clock,
	output logic bus_address_strobe_n,
	output logic [2:0] bus_cmd,
	output logic [3:0] bus_space_code,
	output logic [31:0] bus_addr,
	output idbc_pkg::idbc_word_t bus_word
);
	logic busy, ack_d;
	logic [31:0] cur;
	int acks, a0;
	function automatic idbc_word_t word(input logic [3:0] k, input logic [31:0] a);
		return {a ^ {8{k}}, ~a, 4'h5, k};
	endfunction : word
	initial begin
		bus_clock = 1'b0;
		bus_address_strobe_n = 1'b1;
		bus_cmd = `IDBC_CMD_IDLE;
		bus_space_code = 4'h0;
		bus_addr = 32'h0000_0000;
		bus_word = '0;
		busy = 1'b0;
		acks = 0;
		a0 = 0;
	end
	always #200 bus_clock = ~bus_clock;
	// data follows the line count; off-transaction it toggles so no stale word looks valid
	always @(posedge clk) begin
		ack_d <= bus_ack_oe;
		if (ack_d && !bus_ack_oe)
			acks <= acks + 1;
		bus_word <= busy ? word(4'(acks - a0), cur) : ~bus_word;
	end
	// memory cycles are always whole blocks, io cycles single bytes
	task automatic xact(input logic [2:0] c, input logic [3:0] sp, input logic [31:0] a, input int n);
		@(posedge bus_clock);
		a0 = acks;
		cur = a;
		busy = 1'b1;
		bus_address_strobe_n <= 1'b0;
		bus_cmd <= c;
		bus_space_code <= sp;
		bus_addr <= a;
		@(posedge bus_clock);
		bus_address_strobe_n <= 1'b1;
		bus_cmd <= `IDBC_CMD_IDLE;
		bus_space_code <= ~sp;
		bus_addr <= ~a;
		for (int i = 0; i < 400 && acks - a0 < n; i++)
			@(posedge clk);
		repeat (4) @(posedge bus_clock);
		busy = 1'b0;
	endtask : xact
endmodule : idbc_bus_master

//--- idbc_ctrl_tb.sv
// idbc_ctrl_tb.sv: self-checking bench for the interleaved dram board controller.
// assumes idbc_bus_master as the backplane; the bench models the dram arrays itself.
`timescale 1ns/1ps
`include "idbc_consts.svh"
module idbc_ctrl_tb;
	import idbc_pkg::*;
	logic [3:0] slot = 4'h6;
	logic [3:0] row_col_sel_bank_n, rs_d, cs_d;
	logic [3:0][8:0] dram_addr;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	int error_cnt = 0;
	int checks = 0;
	int cyc = 0;
	int oc = 0;
	logic bus_clock, bus_address_strobe_n, bus_data_oe, bus_ack_oe, int_a_oe, int_b_oe;
	logic wr_reg_a_oe_n, wr_reg_b_oe_n, board_sel, io_sel, wa_d, wb_d, claimed;
	logic [2:0] bus_cmd;
	logic [3:0] bus_space_code;
	logic [31:0] bus_addr, ta;
	logic [7:0] base_addr, bus_check_bits_out;
	logic [63:0] bus_data_out;
	idbc_word_t bw, bin, a_out, b_out, a_in, b_in;
	idbc_word_t m[2] = '{default: '0};
	idbc_word_t wq[$];
	idbc_word_t rq[$];
	idbc_strobe_t [3:0][1:0] dram_ctl;
	assign bin = bus_data_oe ? {bus_data_out, bus_check_bits_out} : bw;
	assign a_in = int_a_oe ? a_out : m[0];
	assign b_in = int_b_oe ? b_out : m[1];
	always #25 clk = ~clk;
	idbc_ctrl idbc_ctrl_i (.clk, .resetn, .bus_clock, .rebuilt_bus_clock(), .bus_address_strobe_n, .bus_cmd,
		.bus_space_code, .board_id_bus(slot), .bus_addr, .bus_data_in(bin.data), .bus_check_bits_in(bin.check),
		.bus_data_out, .bus_check_bits_out, .bus_data_oe, .bus_ack_n_out(), .bus_ack_oe,
		.int_data_a_in(a_in.data), .int_check_a_in(a_in.check), .int_data_a_out(a_out.data),
		.int_check_a_out(a_out.check), .int_a_oe, .int_data_b_in(b_in.data), .int_check_b_in(b_in.check),
		.int_data_b_out(b_out.data), .int_check_b_out(b_out.check), .int_b_oe, .wr_reg_a_oe_n, .wr_reg_b_oe_n,
		.rd_reg_oe_n(), .rd_mux_sel0_n(), .rd_mux_sel1_n(), .addr_reg_enable_n(), .latched_addr(),
		.registered_addr(), .row_col_sel_bank_n, .dram_addr, .dram_ctl, .board_sel, .io_sel, .base_addr);
	idbc_bus_master idbc_bus_master_i (.clk, .bus_ack_oe, .bus_clock, .bus_address_strobe_n, .bus_cmd,
		.bus_space_code, .bus_addr, .bus_word(bw));
	// a bank with its output enable on answers with a known word; otherwise the pair floats to junk
	always @(posedge clk) begin
		m[0] <= ~m[0];
		m[1] <= ~m[1];
		for (int b = 0; b < 4; b++)
			if (!(&{dram_ctl[b][0].oe_n, dram_ctl[b][1].oe_n}))
				m[b % 2] <= idbc_bus_master_i.word(4'(b + 4), ta);
	end
	always @(posedge clk) begin
		wa_d <= wr_reg_a_oe_n;
		wb_d <= wr_reg_b_oe_n;
		oc <= bus_data_oe ? oc + 1 : 0;
		if (wa_d && !wr_reg_a_oe_n)
			wq.push_back(a_out);
		if (wb_d && !wr_reg_b_oe_n)
			wq.push_back(b_out);
		if (oc == 2)
			rq.push_back(bin);
		if (board_sel || io_sel || bus_ack_oe)
			claimed <= 1'b1;
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			error_cnt++;
			$display("MISMATCH cycle_limit expected %0d got %0d", 30000, cyc);
			final_report();
		end
	end
	// a bank must see its row address as its row strobe falls and its column address as its column strobe falls
	always @(posedge clk) begin
		for (int b = 0; b < 4; b++) begin
			rs_d[b] <= &{dram_ctl[b][0].ras_n, dram_ctl[b][1].ras_n};
			cs_d[b] <= &{dram_ctl[b][0].cas_n, dram_ctl[b][1].cas_n};
			if (rs_d[b] && !(&{dram_ctl[b][0].ras_n, dram_ctl[b][1].ras_n}))
				cmp_addr("row_addr", ta[22:14], dram_addr[b]);
			if (cs_d[b] && !(&{dram_ctl[b][0].cas_n, dram_ctl[b][1].cas_n})) begin
				cmp_addr("col_addr", ta[13:5], dram_addr[b]);
				cmp("col_select", 72'h0, 72'(row_col_sel_bank_n[b]));
			end
		end
	end
	task automatic cmp_addr(input string nm, input logic [8:0] e, input logic [8:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h got %h", nm, e, g);
		end
	endtask : cmp_addr
	task automatic cmp(input string nm, input logic [71:0] e, input logic [71:0] g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h got %h", nm, e, g);
		end
	endtask : cmp
	task automatic final_report;
		if (error_cnt == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report
	initial begin
		logic [31:0] a;
		logic [7:0] base;
		void'($urandom(32'h8accba63));
		claimed = 1'b0;
		ta = 32'h0000_0000;
		repeat (10) @(posedge clk);
		resetn <= 1'b1;
		@(posedge clk);
		cmp("base_reset", 72'(`IDBC_BASE_RST), 72'(base_addr));
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			slot <= 4'($urandom);
			@(posedge clk);
			base = {4'($urandom), slot};
			a = {base, 6'($urandom), `IDBC_IO_LOCREG, 16'($urandom)};
			idbc_bus_master_i.xact(`IDBC_CMD_IO_WR, `IDBC_IO_SPACE, a, 1);
			cmp("base_addr", 72'(base), 72'(base_addr));
			rq.delete();
			idbc_bus_master_i.xact(`IDBC_CMD_IO_RD, `IDBC_IO_SPACE, a, 1);
			cmp("io_read", 72'(base), 72'(rq[0].data[63:56]));
			idbc_bus_master_i.xact(`IDBC_CMD_IO_WR, `IDBC_IO_SPACE, a ^ 32'h0002_0000, 1);
			rq.delete();
			idbc_bus_master_i.xact(`IDBC_CMD_IO_RD, `IDBC_IO_SPACE, a ^ 32'h0002_0000, 1);
			cmp("io_other", 72'h0, 72'(rq[0].data[63:56]));
			a = {base, i[0], (i == 1) ? 18'h3_ffff : 18'($urandom), 5'h00};
			ta = a;
			wq.delete();
			idbc_bus_master_i.xact(`IDBC_CMD_MEM_WR, 4'h0, a, 4);
			for (int k = 0; k < 4; k++)
				cmp("wr_line", idbc_bus_master_i.word(4'(k), a), wq[k]);
			rq.delete();
			idbc_bus_master_i.xact(`IDBC_CMD_MEM_RD, 4'h0, a, 4);
			for (int k = 0; k < 4; k++)
				cmp("rd_line", idbc_bus_master_i.word(4'(k + 4), a), rq[k]);
			claimed = 1'b0;
			idbc_bus_master_i.xact(`IDBC_CMD_MEM_WR, 4'h0, a ^ 32'h0100_0000, 0);
			idbc_bus_master_i.xact(`IDBC_CMD_IO_WR, 4'h2, {base, 24'h02_0000}, 0);
			idbc_bus_master_i.xact(`IDBC_CMD_IO_WR, `IDBC_IO_SPACE, {base ^ 8'h01, 24'h02_0000}, 0);
			cmp("unclaimed", 72'h0, 72'(claimed));
			cmp("base_kept", 72'(base), 72'(base_addr));
		end
		final_report();
	end
endmodule : idbc_ctrl_tb
